// ### verilog/spdma_params.svh
`ifndef SPDMA_PARAMS_SVH
`define SPDMA_PARAMS_SVH
// Port and channel counts
`define SP_NPORT 6
`define SP_NCHAN 12
// Address groups of the register space, one per pair of ports
`define GRP_BASE0 12'hc00
`define GRP_BASE1 12'h400
`define GRP_BASE2 12'h800
// Offsets inside a group
`define CTL_OFS 12'h000
`define DIV_OFS 12'h002
`define PAR_OFS 12'h040
`define PAR_PORT_STRIDE 12'h008
`define PAR_CHAN_STRIDE 12'h004
// Parameter register selectors
`define P_INDEX 12'h000
`define P_STEP 12'h001
`define P_COUNT 12'h002
`define P_CHAIN 12'h003
// Port control register fields
`define B_EN_A 0
`define B_WORD_LENGTH_FIELD_LO 4
`define B_WORD_LENGTH_FIELD_HI 8
`define B_PACK 11
`define B_FSINT 14
`define B_DMA_A 18
`define B_CHN_A 19
`define B_DMA_B 20
`define B_CHN_B 21
`define B_EN_B 24
`define B_DIR 25
`define B_RDY_A 30
`define B_RDY_B 31
`define CTL_RO_MASK 32'hc000_0000
`define CTL_RST 32'h0000_0000
// Divisor register field
`define DIV_FS_LO 16
// Longest word length code that still packs
`define PACK_MAX_WORD_LENGTH_FIELD 5'h0f
// Serial clocks from enable to ready
`define READY_TICKS 2'h2
`endif

// ### verilog/spdma_pkg.sv
package spdma_pkg;
	typedef logic [18:0] index_t; // Start index address
	typedef logic [15:0] step_t; // Signed modify step
	typedef logic [15:0] count_t; // Word count
	typedef logic [19:0] chain_t; // Next descriptor pointer
	typedef logic [11:0] addr_t; // Register address
	typedef logic [31:0] word_t; // Register data
endpackage

// ### verilog/spdma_ctrl.sv
// What this block does
// - Frame syncs spaced divisor plus one ticks
// - Divisor zero holds frame sync active
// - Enabled idle port still divides serial clock
// - Clearing enable aborts channel, clears status
// - Channel ready two serial clocks after enable
// - Reset clears every port control register
// - One merged interrupt per port
// - Port interrupt priority 1,3,5,0,2,4
// - Interrupt two clocks after word end, three at a DMA block end
// - Without DMA, interrupt on every word
// - Twelve channels, fixed port mapping, 0 highest
// - Direction bit picks receive or transmit buffer
// - Serial DMA beats other requesters
// - Word length 3..32, DMA moves 32 bits
// - Packing merges short words, interrupts per pair
// - Separate DMA and chain enables per channel
// - Four parameter registers per channel
// - DMA moves words until buffer done
// - Count reaching zero raises port interrupt
// - Signed step added to index each word
// - Core writes all parameters, host all but the chain pointer
// - Count decrements, zero clears the channel's DMA enable
`timescale 1ns/1ps
`include "spdma_params.svh"
module spdma_ctrl #(
	parameter int NPORT = `SP_NPORT,
	parameter int NCHAN = `SP_NCHAN
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic iop_wr,
	input wire logic iop_rd,
	input wire spdma_pkg::addr_t iop_addr,
	input wire spdma_pkg::word_t iop_wdata,
	output spdma_pkg::word_t iop_rdata,
	input wire logic host_wr,
	input wire spdma_pkg::addr_t host_addr,
	input wire spdma_pkg::word_t host_wdata,
	input wire logic [NPORT-1:0] sclk_tick,
	input wire logic [NCHAN-1:0] rx_word_done,
	input wire logic [NCHAN-1:0] tx_vacant,
	output logic [NPORT-1:0] fs_out,
	output logic [NCHAN-1:0] chan_ready,
	output logic [NCHAN-1:0] buf_is_tx,
	input wire logic other_dma_req,
	output logic other_dma_gnt,
	output logic dma_valid,
	output logic [3:0] dma_channel,
	output spdma_pkg::index_t dma_addr,
	output logic dma_to_tx,
	output logic chain_start,
	output spdma_pkg::chain_t chain_ptr,
	output logic [NPORT-1:0] port_irq,
	output logic irq_any,
	output logic [2:0] irq_top_port
);
	// Port owning a channel: channel pairs go to ports 1,0,3,2,5,4
	function automatic logic [2:0] chan_port(input logic [3:0] c);
		chan_port = c[3:1] ^ 3'h1;
	endfunction
	// Base of the address group shared by a pair of ports
	function automatic spdma_pkg::addr_t grp_base(input logic [2:0] p);
		unique case (p[2:1])
			2'h0: grp_base = `GRP_BASE0;
			2'h1: grp_base = `GRP_BASE1;
			default: grp_base = `GRP_BASE2;
		endcase
	endfunction
	// Address of one parameter register of a channel
	function automatic spdma_pkg::addr_t par_addr(input logic [3:0] c, input spdma_pkg::addr_t r);
		logic [2:0] p;
		p = chan_port(c);
		par_addr = grp_base(p) + `PAR_OFS + (p[0] ? `PAR_PORT_STRIDE : 12'h000)
			+ (c[0] ? `PAR_CHAN_STRIDE : 12'h000) + r;
	endfunction
	// Next index: signed step widened to the index width
	function automatic spdma_pkg::index_t next_index(input spdma_pkg::index_t i,
		input spdma_pkg::step_t s);
		next_index = i + {{3{s[15]}}, s};
	endfunction

	logic [31:0] ctl_reg [NPORT]; // Port control registers
	logic [15:0] frame_sync_divisor_reg [NPORT]; // Frame sync divisors
	logic [15:0] fs_cnt_reg [NPORT]; // Serial clocks since last frame sync
	spdma_pkg::index_t idx_reg [NCHAN];
	spdma_pkg::step_t step_reg [NCHAN];
	spdma_pkg::count_t cnt_reg [NCHAN];
	spdma_pkg::chain_t chain_reg [NCHAN];
	logic [1:0] rdy_cnt_reg [NCHAN]; // Serial clocks since enable
	logic [1:0] rdy_next [NCHAN];
	logic [NCHAN-1:0] pack_ph_reg; // Half of a packed word seen
	logic [NCHAN-1:0] ev_reg; // Completed word, one clock late
	logic [NCHAN-1:0] pend_reg; // DMA requests waiting for a grant
	logic [NCHAN-1:0] pend_next;
	logic [NCHAN-1:0] ch_en, ch_dma, ch_chain, ch_dir, ch_pack;
	logic [NCHAN-1:0] word_ev, full_ev, grant, done;
	logic [NPORT-1:0] port_on, irq_next;
	logic wr_en, wr_host;
	spdma_pkg::addr_t wr_addr;
	spdma_pkg::word_t wr_data, rd_next;
	logic [3:0] gnt_idx;

	// One write port: the core wins when both write in the same cycle
	always_comb begin
		wr_en = iop_wr | host_wr;
		wr_host = host_wr & ~iop_wr;
		wr_addr = iop_wr ? iop_addr : host_addr;
		wr_data = iop_wr ? iop_wdata : host_wdata;
	end

	// Per-channel view of the owning port's control bits
	always_comb begin
		for (int c = 0; c < NCHAN; c++) begin
			logic [31:0] ctl;
			ctl = ctl_reg[chan_port(4'(c))];
			ch_en[c] = c[0] ? ctl[`B_EN_B] : ctl[`B_EN_A];
			ch_dma[c] = c[0] ? ctl[`B_DMA_B] : ctl[`B_DMA_A];
			ch_chain[c] = c[0] ? ctl[`B_CHN_B] : ctl[`B_CHN_A];
			ch_dir[c] = ctl[`B_DIR];
			// Only words of 16 bits or less pack
			ch_pack[c] = ctl[`B_PACK] && (ctl[`B_WORD_LENGTH_FIELD_HI:`B_WORD_LENGTH_FIELD_LO] <= `PACK_MAX_WORD_LENGTH_FIELD);
			// Direction picks which buffer's events count
			word_ev[c] = ch_en[c] && chan_ready[c]
				&& (ch_dir[c] ? tx_vacant[c] : rx_word_done[c]);
			full_ev[c] = word_ev[c] && (!ch_pack[c] || pack_ph_reg[c]);
			rdy_next[c] = !ch_en[c] ? 2'h0
				: (sclk_tick[chan_port(4'(c))] && rdy_cnt_reg[c] != `READY_TICKS)
				? rdy_cnt_reg[c] + 2'h1 : rdy_cnt_reg[c];
		end
		for (int p = 0; p < NPORT; p++) begin
			port_on[p] = ctl_reg[p][`B_EN_A] | ctl_reg[p][`B_EN_B];
		end
	end

	// Ready counter: two serial clocks after enable, then holds
	always_ff @(posedge clk) begin
		for (int c = 0; c < NCHAN; c++) begin
			if (sys_rst) begin
				rdy_cnt_reg[c] <= 2'h0;
				chan_ready[c] <= 1'b0;
			end else begin
				rdy_cnt_reg[c] <= rdy_next[c];
				chan_ready[c] <= rdy_next[c] == `READY_TICKS;
			end
		end
	end

	// Active buffer per channel follows the direction bit
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			buf_is_tx <= '0;
		end else begin
			buf_is_tx <= ch_dir;
		end
	end

	// Packing phase and the one-clock word event; disable wipes both
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pack_ph_reg <= '0;
			ev_reg <= '0;
		end else begin
			for (int c = 0; c < NCHAN; c++) begin
				if (!ch_en[c]) begin
					pack_ph_reg[c] <= 1'b0;
				end else if (word_ev[c] && ch_pack[c]) begin
					pack_ph_reg[c] <= ~pack_ph_reg[c];
				end
			end
			ev_reg <= full_ev & ch_en;
		end
	end

	// Lowest numbered pending channel wins, one grant per clock
	always_comb begin
		grant = '0;
		gnt_idx = 4'h0;
		for (int c = NCHAN - 1; c >= 0; c--) begin
			if (pend_reg[c]) begin
				grant = '0;
				grant[c] = 1'b1;
				gnt_idx = 4'(c);
			end
		end
		for (int c = 0; c < NCHAN; c++) begin
			done[c] = grant[c] && cnt_reg[c] == 16'h0001;
		end
		// A new word beats the grant that clears the same bit
		pend_next = (pend_reg & ~grant & ch_en & ch_dma)
			| (ev_reg & ch_dma & ch_en);
		for (int c = 0; c < NCHAN; c++) begin
			if (cnt_reg[c] == 16'h0000) begin
				pend_next[c] = 1'b0;
			end
		end
	end

	// Request register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pend_reg <= '0;
		end else begin
			pend_reg <= pend_next;
		end
	end

	// Memory side of a grant, 32-bit word each
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dma_valid <= 1'b0;
			dma_channel <= 4'h0;
			dma_addr <= '0;
			dma_to_tx <= 1'b0;
			chain_start <= 1'b0;
			chain_ptr <= '0;
			other_dma_gnt <= 1'b0;
		end else begin
			dma_valid <= |pend_reg;
			dma_channel <= gnt_idx;
			dma_addr <= idx_reg[gnt_idx];
			dma_to_tx <= ch_dir[gnt_idx];
			// Chaining needs a nonzero pointer as well as its enable
			chain_start <= |(done & ch_chain) && chain_reg[gnt_idx] != '0;
			chain_ptr <= chain_reg[gnt_idx];
			// Other requesters only get the bus when no serial channel waits
			other_dma_gnt <= other_dma_req & ~|pend_reg;
		end
	end

	// Parameter registers: writes first, else grant updates
	always_ff @(posedge clk) begin
		for (int c = 0; c < NCHAN; c++) begin
			if (sys_rst) begin
				idx_reg[c] <= '0;
				step_reg[c] <= '0;
				cnt_reg[c] <= '0;
				chain_reg[c] <= '0;
			end else begin
				if (wr_en && wr_addr == par_addr(4'(c), `P_STEP)) begin
					step_reg[c] <= wr_data[15:0];
				end
				if (wr_en && !wr_host && wr_addr == par_addr(4'(c), `P_CHAIN)) begin
					chain_reg[c] <= wr_data[19:0];
				end
				if (wr_en && wr_addr == par_addr(4'(c), `P_INDEX)) begin
					idx_reg[c] <= wr_data[18:0];
				end else if (grant[c]) begin
					idx_reg[c] <= next_index(idx_reg[c], step_reg[c]);
				end
				if (wr_en && wr_addr == par_addr(4'(c), `P_COUNT)) begin
					cnt_reg[c] <= wr_data[15:0];
				end else if (grant[c]) begin
					cnt_reg[c] <= cnt_reg[c] - 16'h0001;
				end
			end
		end
	end

	// Control and divisor registers; finishing a block clears its DMA enable
	always_ff @(posedge clk) begin
		for (int p = 0; p < NPORT; p++) begin
			if (sys_rst) begin
				ctl_reg[p] <= `CTL_RST;
				frame_sync_divisor_reg[p] <= 16'h0000;
			end else begin
				if (wr_en && !wr_host && wr_addr == grp_base(3'(p)) + `CTL_OFS + 12'(p % 2)) begin
					ctl_reg[p] <= wr_data & ~`CTL_RO_MASK;
				end
				if (wr_en && !wr_host && wr_addr == grp_base(3'(p)) + `DIV_OFS + 12'(p % 2)) begin
					frame_sync_divisor_reg[p] <= wr_data[31:`DIV_FS_LO];
				end
				for (int c = 0; c < NCHAN; c++) begin
					if (done[c] && chan_port(4'(c)) == 3'(p)) begin
						ctl_reg[p][c[0] ? `B_DMA_B : `B_DMA_A] <= 1'b0;
					end
				end
			end
		end
	end

	// Frame sync divider runs whenever the port is enabled and its B_FSINT bit is set, data or not
	always_ff @(posedge clk) begin
		for (int p = 0; p < NPORT; p++) begin
			if (sys_rst || !port_on[p] || !ctl_reg[p][`B_FSINT]) begin
				fs_cnt_reg[p] <= 16'h0000;
				fs_out[p] <= 1'b0;
			end else if (frame_sync_divisor_reg[p] == 16'h0000) begin
				fs_out[p] <= 1'b1;
			end else if (sclk_tick[p]) begin
				// A pulse lasts one clock, spaced divisor plus one serial clocks
				if (fs_cnt_reg[p] == frame_sync_divisor_reg[p]) begin
					fs_cnt_reg[p] <= 16'h0000;
					fs_out[p] <= 1'b1;
				end else begin
					fs_cnt_reg[p] <= fs_cnt_reg[p] + 16'h0001;
					fs_out[p] <= 1'b0;
				end
			end else begin
				fs_out[p] <= 1'b0;
			end
		end
	end

	// Merge both channels of a port onto its one interrupt
	always_comb begin
		irq_next = '0;
		for (int c = 0; c < NCHAN; c++) begin
			if ((ev_reg[c] && !ch_dma[c]) || done[c]) begin
				irq_next[chan_port(4'(c))] = 1'b1;
			end
		end
	end

	// Interrupt pulses, two clocks after the word end, three after it for a DMA block end; fixed priority encode
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			port_irq <= '0;
			irq_any <= 1'b0;
			irq_top_port <= 3'h0;
		end else begin
			port_irq <= irq_next;
			irq_any <= |irq_next;
			// Highest first: 1, 3, 5, 0, 2, 4
			if (irq_next[1]) irq_top_port <= 3'h1;
			else if (irq_next[3]) irq_top_port <= 3'h3;
			else if (irq_next[5]) irq_top_port <= 3'h5;
			else if (irq_next[0]) irq_top_port <= 3'h0;
			else if (irq_next[2]) irq_top_port <= 3'h2;
			else if (irq_next[4]) irq_top_port <= 3'h4;
			else irq_top_port <= 3'h0;
		end
	end

	// Read decode; unmapped addresses read zero
	always_comb begin
		rd_next = '0;
		for (int p = 0; p < NPORT; p++) begin
			if (iop_addr == grp_base(3'(p)) + `CTL_OFS + 12'(p % 2)) begin
				rd_next = ctl_reg[p];
				// Port p owns channel pair p^1, so the same swap maps back
				rd_next[`B_RDY_A] = chan_ready[{3'(p) ^ 3'h1, 1'b0}];
				rd_next[`B_RDY_B] = chan_ready[{3'(p) ^ 3'h1, 1'b1}];
			end
			if (iop_addr == grp_base(3'(p)) + `DIV_OFS + 12'(p % 2)) begin
				rd_next = {frame_sync_divisor_reg[p], 16'h0000};
			end
		end
		for (int c = 0; c < NCHAN; c++) begin
			if (iop_addr == par_addr(4'(c), `P_INDEX)) rd_next = {13'h0000, idx_reg[c]};
			if (iop_addr == par_addr(4'(c), `P_STEP)) rd_next = {16'h0000, step_reg[c]};
			if (iop_addr == par_addr(4'(c), `P_COUNT)) rd_next = {16'h0000, cnt_reg[c]};
			if (iop_addr == par_addr(4'(c), `P_CHAIN)) rd_next = {12'h000, chain_reg[c]};
		end
	end

	// Read data register, held until the next read
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			iop_rdata <= '0;
		end else if (iop_rd) begin
			iop_rdata <= rd_next;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	fs_hold_a: assert property (port_on[0] && ctl_reg[0][`B_FSINT] && frame_sync_divisor_reg[0] == 16'h0000
		|=> fs_out[0]) else $error("frame sync not held at divisor zero");
	fs_tick_a: assert property ($rose(fs_out[0]) && $past(frame_sync_divisor_reg[0]) != 16'h0000
		|-> $past(sclk_tick[0])) else $error("frame sync without serial clock");
	irq_delay_a: assert property (word_ev[0] && !ch_dma[0] && !ch_pack[0] && !wr_en
		|-> ##2 port_irq[1]) else $error("word interrupt late or missing");
	top_prio_a: assert property (port_irq[1] |-> irq_top_port == 3'h1)
		else $error("port one not on top");
	grant_low_a: assert property (pend_reg[0] |=> dma_valid && dma_channel == 4'h0)
		else $error("channel zero not granted first");
	other_gnt_a: assert property (other_dma_req && |pend_reg |=> !other_dma_gnt)
		else $error("other requester beat serial DMA");
	index_step_a: assert property (grant[0] && !wr_en
		|=> idx_reg[0] == next_index($past(idx_reg[0]), $past(step_reg[0]))
		&& dma_addr == $past(idx_reg[0])) else $error("index not stepped");
	count_dec_a: assert property (grant[0] && !wr_en
		|=> cnt_reg[0] == $past(cnt_reg[0]) - 16'h0001) else $error("count not decremented");
	auto_off_a: assert property (done[0] && !wr_en |=> !ch_dma[0] && port_irq[1])
		else $error("block end not flagged or not disabled");
	abort_clear_a: assert property (!ch_en[0] |=> !pend_reg[0] && !pack_ph_reg[0]
		&& !chan_ready[0]) else $error("disable left state behind");
	ready_two_a: assert property ($rose(chan_ready[0]) |-> $past(sclk_tick[1]))
		else $error("ready without serial clock");

	dma_block_c: cover property (done[0] ##2 port_irq[1]);
	fs_pulse_c: cover property ($rose(fs_out[0]));
	pack_pair_c: cover property (ch_pack[0] && full_ev[0]);
	chain_c: cover property (chain_start);
endmodule // spdma_ctrl

// ### verif/sp_far_model.sv
`timescale 1ns/1ps
// Far side of the ports: serial clock pins and the word shifters
module sp_far_model #(
	parameter int TICK_DIV = 3
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic tick_on,
	input wire logic [11:0] word_req,
	input wire logic [11:0] buf_is_tx,
	output logic [5:0] sclk_tick,
	output logic [11:0] rx_word_done,
	output logic [11:0] tx_vacant
);
	int cnt; // Serial clock divider
	// Serial clock stands still unless frames are wanted
	always_ff @(posedge clk) begin
		if (sys_rst || !tick_on) begin
			cnt <= 0;
			sclk_tick <= 6'h00;
		end else begin
			cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
			sclk_tick <= {6{cnt == TICK_DIV - 1}};
		end
	end
	// A word end lands only on the buffer that the direction bit made active
	always_ff @(posedge clk) begin
		rx_word_done <= sys_rst ? 12'h000 : word_req & ~buf_is_tx;
		tx_vacant <= sys_rst ? 12'h000 : word_req & buf_is_tx;
	end
endmodule // sp_far_model

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
	localparam int TD = 3; // Serial clock period in clk cycles
	localparam int LIMIT = 4000; // Whole run needs well under this
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic iop_wr = 1'b0, iop_rd = 1'b0, host_wr = 1'b0, other_dma_req = 1'b0, tick_on = 1'b0;
	spdma_pkg::addr_t iop_addr = 12'h000, host_addr = 12'h000;
	spdma_pkg::word_t iop_wdata = 32'h0, host_wdata = 32'h0, iop_rdata, rd_d;
	logic [11:0] word_req = 12'h000; // Word end requests to the far side
	logic [5:0] sclk_tick, fs_out, port_irq, irq_v;
	logic [11:0] rx_word_done, tx_vacant, chan_ready, buf_is_tx;
	logic other_dma_gnt, dma_valid, dma_to_tx, chain_start, irq_any;
	logic [3:0] dma_channel;
	logic [2:0] irq_top_port, top_v;
	spdma_pkg::index_t dma_addr;
	spdma_pkg::chain_t chain_ptr, chp;
	int miscompares = 0, checks = 0, cyc = 0, ev_cyc, irq_cyc, n_irq, fs_a, fs_b, nt, nd;
	int dcy[8]; // Log of transfers: cycle, channel, address, other grant
	logic [3:0] dch[8];
	spdma_pkg::index_t dad[8];
	logic dgn[8];
	logic dtx[8]; // Direction of each logged transfer
	logic any_v; // Merged interrupt flag seen with the last port interrupt

	sp_far_model #(.TICK_DIV(TD)) u_far (.clk, .sys_rst, .tick_on, .word_req, .buf_is_tx,
		.sclk_tick, .rx_word_done, .tx_vacant);
	spdma_ctrl u_dut (.clk, .sys_rst, .iop_wr, .iop_rd, .iop_addr, .iop_wdata, .iop_rdata,
		.host_wr, .host_addr, .host_wdata, .sclk_tick, .rx_word_done, .tx_vacant, .fs_out,
		.chan_ready, .buf_is_tx, .other_dma_req, .other_dma_gnt, .dma_valid, .dma_channel,
		.dma_addr, .dma_to_tx, .chain_start, .chain_ptr, .port_irq, .irq_any, .irq_top_port);

	always #2.5 clk = ~clk;

	// Output log, in cycles; values seen here are those before each edge
	always @(posedge clk) begin
		cyc++;
		if (|(rx_word_done | tx_vacant)) ev_cyc = cyc;
		if (|port_irq) begin
			irq_cyc = cyc;
			irq_v = port_irq;
			top_v = irq_top_port;
			any_v = irq_any;
			n_irq++;
		end
		if (fs_out[1]) begin
			fs_a = fs_b;
			fs_b = cyc;
		end
		if (sclk_tick[1]) nt++;
		if (chain_start) chp = chain_ptr;
		if (dma_valid && nd < 8) begin
			dcy[nd] = cyc;
			dch[nd] = dma_channel;
			dad[nd] = dma_addr;
			dgn[nd] = other_dma_gnt;
			dtx[nd] = dma_to_tx;
			nd++;
		end
		// A hang ends the run here
		if (cyc == LIMIT) begin
			miscompares++;
			summarize();
		end
	end

	task automatic chk(input spdma_pkg::word_t got, input spdma_pkg::word_t exp);
		checks++;
		if (got !== exp) begin
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			miscompares++;
		end
	endtask
	// One core write; strobe held through the taking edge
	task automatic wr(input spdma_pkg::addr_t a, input spdma_pkg::word_t d);
		@(posedge clk);
		iop_wr <= 1'b1;
		iop_addr <= a;
		iop_wdata <= d;
		@(posedge clk);
		iop_wr <= 1'b0;
	endtask
	// Read data is registered, so it is taken half a cycle after the edge
	task automatic rd(input spdma_pkg::addr_t a);
		@(posedge clk);
		iop_rd <= 1'b1;
		iop_addr <= a;
		@(posedge clk);
		iop_rd <= 1'b0;
		@(negedge clk);
		rd_d = iop_rdata;
	endtask
	// Control write plus time for the two serial clocks before ready
	task automatic ctl(input spdma_pkg::addr_t a, input spdma_pkg::word_t d);
		wr(a, d);
		repeat (4 * TD) @(posedge clk);
	endtask
	task automatic ev(input logic [11:0] m, input int w);
		@(posedge clk);
		word_req <= m;
		@(posedge clk);
		word_req <= 12'h000;
		repeat (w) @(posedge clk);
	endtask
	task automatic summarize();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic t_regs();
		rd(12'hc01);
		chk(rd_d, 32'h0);
		wr(12'hc48, 32'hffff_ffff);
		rd(12'hc48);
		chk(rd_d, 32'h0007_ffff);
		wr(12'hc4b, 32'hffff_ffff);
		rd(12'hc4b);
		chk(rd_d, 32'h000f_ffff);
		// Host sets the step of channel 0 that the DMA run relies on
		@(posedge clk);
		host_wr <= 1'b1;
		host_addr <= 12'hc49;
		host_wdata <= 32'h0000_fffe;
		@(posedge clk);
		host_wr <= 1'b0;
		rd(12'hc49);
		chk(rd_d, 32'h0000_fffe);
		rd(12'hc50);
		chk(rd_d, 32'h0);
	endtask
	task automatic t_ready();
		@(posedge clk);
		tick_on <= 1'b0;
		wr(12'hc01, 32'h0000_0001);
		repeat (6) @(negedge clk);
		chk(32'(chan_ready[0]), 32'h0);
		@(posedge clk);
		nt = 0;
		tick_on <= 1'b1;
		for (int k = 0; k < 40 && chan_ready[0] !== 1'b1; k++) @(negedge clk);
		chk(32'(nt), 32'h2);
	endtask
	task automatic t_fs();
		ctl(12'hc01, 32'h0000_4031);
		wr(12'hc03, 32'h0003_0000);
		repeat (12 * TD) @(posedge clk);
		chk(32'(fs_b - fs_a), 32'(4 * TD));
		wr(12'hc03, 32'h0);
		repeat (3) @(posedge clk);
		repeat (4) begin
			@(negedge clk);
			chk(32'(fs_out[1]), 32'h1);
		end
	endtask
	task automatic t_word();
		spdma_pkg::word_t cfg[3] = '{32'h0000_0001, 32'h0200_0001, 32'h0100_0000};
		for (int i = 0; i < 3; i++) begin
			ctl(12'hc01, cfg[i]);
			chk(32'(buf_is_tx[i / 2]), 32'(cfg[i][25]));
			ev(12'h001 << (i / 2), 6);
			chk(32'(irq_cyc - ev_cyc), 32'h2);
			chk(32'(irq_v), 32'h02);
		end
	endtask
	// Packed short words: only every second word interrupts
	task automatic t_pack();
		ctl(12'hc01, 32'h0000_0801);
		n_irq = 0;
		ev(12'h001, 6);
		chk(32'(n_irq), 32'h0);
		ev(12'h001, 6);
		chk(32'(n_irq), 32'h1);
		chk(32'(any_v), 32'h1);
	endtask
	task automatic t_dma();
		wr(12'hc48, 32'h0000_0100);
		wr(12'hc4a, 32'h0000_0002);
		ctl(12'hc01, 32'h000c_0001);
		nd = 0;
		ev(12'h001, 6);
		chk(32'(dcy[0] - ev_cyc), 32'h3);
		ev(12'h001, 6);
		chk(32'(nd), 32'h2);
		chk(32'(dad[0]), 32'h100);
		chk(32'(dtx[0]), 32'h0);
		chk(32'(dad[1]), 32'h0fe);
		chk(32'(irq_cyc), 32'(dcy[1]));
		chk(32'(chp), 32'h000f_ffff);
		rd(12'hc01);
		chk(32'(rd_d[18]), 32'h0);
	endtask
	task automatic t_prio();
		wr(12'hc42, 32'h1);
		wr(12'hc4a, 32'h1);
		wr(12'hc00, 32'h0004_0001);
		ctl(12'hc01, 32'h0004_0001);
		other_dma_req <= 1'b1;
		nd = 0;
		ev(12'h005, 8);
		chk(32'(dch[0]), 32'h0);
		chk(32'(dch[1]), 32'h2);
		chk(32'(dcy[1] - dcy[0]), 32'h1);
		chk(32'({dgn[0], dgn[1]}), 32'h0);
		@(negedge clk);
		chk(32'(other_dma_gnt), 32'h1);
		@(posedge clk);
		other_dma_req <= 1'b0;
		// Both blocks are done, so ports 0 and 1 now interrupt per word
		ctl(12'h801, 32'h0000_0001);
		ev(12'h105, 6);
		chk(32'(irq_v), 32'h23);
		chk(32'(top_v), 32'h1);
		ev(12'h104, 6);
		chk(32'(top_v), 32'h5);
	endtask
	task automatic t_abort();
		ctl(12'hc01, 32'h0);
		chk(32'(chan_ready[0]), 32'h0);
		n_irq = 0;
		ev(12'h001, 6);
		chk(32'(n_irq), 32'h0);
		// Reset in mid-run with a port enabled
		wr(12'hc01, 32'h1);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(12'hc01);
		chk(rd_d, 32'h0);
		chk(32'(chan_ready), 32'h0);
	endtask

	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		tick_on <= 1'b1;
		t_regs();
		t_ready();
		t_fs();
		t_word();
		t_pack();
		t_dma();
		t_prio();
		t_abort();
		summarize();
	end
endmodule // tb
